// ---- design/pscmd_handler.sv ----
// What this block does
// - Four selectors, each with permitted authentication levels
// - Level-two key disabled blocks init and return
// - Success reply: code 51h, state 00h, unused
// - Failure reply D1h; all replies 81h, 0Ah, end
// - Discard bytes until command start marker
// - Missing end marker gives packet error
// - Bad check byte gives checksum error
// - Bad length bytes give packet error
// - After errors nothing written, back to waiting
// - Lifecycle forbids command: acceptance error
// - Unsupported selector gives parameter error
// - Level not permitted gives secure error
// - Level-one key after encrypted write refused
// - Bad value byte gives parameter error
// - Value low three bits zero, upper ignored
// - Already disabled: skip write, reply success
// - Disabled functions never re-enabled
// - Flash write failure gives flash access error
// - Flash error reply carries flash status word
// - Completed write replies success, then waits
// - Only highest-priority failure is reported
// - Non-flash failures use unused pattern both words
`timescale 1ns/10ps
module pscmd_handler (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // Boot link byte stream
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    input  wire logic        tx_ready,
    // Device context
    input  wire logic [3:0]  lifecycle_state,
    input  wire logic [1:0]  authentication_level,
    input  wire logic        encrypted_write_pending,
    input  wire logic [3:0]  stored_disables,
    // Flash controller
    output logic             flash_req,
    output logic [1:0]       flash_index,
    input  wire logic        flash_done,
    input  wire logic        flash_fail,
    input  wire logic [31:0] flash_status,
    // Function gates
    output logic [3:0]       function_disabled,
    output logic             init_allowed,
    output logic             return_request_allowed
);

    pscmd_pkg::pscmd_state_e state;
    pscmd_pkg::pscmd_state_e next_state;

    logic        enable;
    logic [15:0] life_permit;
    logic [7:0]  last_state_code;
    logic        loaded;
    logic [7:0]  len_high;
    logic [7:0]  len_low;
    logic [7:0]  opcode;
    logic [7:0]  selector;
    logic [7:0]  value;
    logic [7:0]  check_byte;
    logic [7:0]  end_byte;
    logic        reply_start;
    logic [7:0]  reply_code;
    logic [7:0]  reply_state;
    logic [31:0] reply_detail;
    logic        reply_done;

    // Bus slave: address phase captured, acted on in data phase
    logic        bus_wr;
    logic [7:0]  addr_word;
    logic [7:0]  bus_addr;
    logic        addr_phase;
    logic [31:0] status_word;
    logic [31:0] read_mux;

    assign addr_phase  = hsel && hready && htrans[1];
    assign addr_word   = {haddr[7:2], 2'b00};
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign status_word = {15'h0000, (state != pscmd_pkg::PSCMD_WAIT_START),
                          last_state_code, 4'h0, function_disabled};
    assign read_mux    = (addr_word == pscmd_pkg::REG_CONTROL)     ? {31'h0, enable} :
                         (addr_word == pscmd_pkg::REG_LIFE_PERMIT) ? {16'h0000, life_permit} :
                         (addr_word == pscmd_pkg::REG_STATUS)      ? status_word :
                         32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_wr   <= 1'b0;
            bus_addr <= 8'h00;
        end else begin
            bus_wr   <= addr_phase && hwrite;
            bus_addr <= addr_word;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            // No wait state: word must stand in the data phase
            hrdata <= read_mux;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable      <= pscmd_pkg::CONTROL_RESET;
            life_permit <= pscmd_pkg::LIFE_PERMIT_RESET;
        end else if (bus_wr && bus_addr == pscmd_pkg::REG_CONTROL) begin
            enable <= hwdata[0];
        end else if (bus_wr && bus_addr == pscmd_pkg::REG_LIFE_PERMIT) begin
            life_permit <= hwdata[15:0];
        end
    end

    // Packet checks, in order of priority
    logic [7:0]  byte_sum;
    logic [15:0] length;
    logic        end_bad;
    logic        sum_bad;
    logic        format_bad;
    logic        cmd_len_bad;
    logic        life_bad;
    logic        selector_bad;
    logic        auth_bad;
    logic        after_write_bad;
    logic        value_bad;
    logic [1:0]  sel_index;
    logic        already_off;
    logic        error_found;
    logic [7:0]  error_code;

    assign byte_sum    = len_high + len_low + opcode +
                         selector + value + check_byte;
    assign length      = {len_high, len_low};
    assign end_bad     = end_byte != pscmd_pkg::PACKET_END_MARKER;
    assign sum_bad     = byte_sum != 8'h00;
    assign format_bad  = length == 16'h0000;
    assign cmd_len_bad = length != pscmd_pkg::CMD_LENGTH;
    assign life_bad    = !life_permit[lifecycle_state];
    assign selector_bad = selector < pscmd_pkg::SEL_INIT ||
                          selector > pscmd_pkg::SEL_L1_KEY;
    assign sel_index   = 2'(selector - pscmd_pkg::SEL_INIT);

    // Permitted levels per selector
    always_comb begin
        unique case (selector)
            pscmd_pkg::SEL_INIT:      auth_bad = 1'b0;
            pscmd_pkg::SEL_L2_KEY:    auth_bad = authentication_level != pscmd_pkg::AUTH_LEVEL2;
            default:                  auth_bad = authentication_level == pscmd_pkg::AUTH_LEVEL0;
        endcase
    end

    assign after_write_bad = encrypted_write_pending &&
                             selector == pscmd_pkg::SEL_L1_KEY;
    assign value_bad   = value[2:0] != 3'b000;
    assign already_off = function_disabled[sel_index];

    // First failing check wins
    assign error_found = end_bad || sum_bad || format_bad || cmd_len_bad || life_bad ||
                         selector_bad || auth_bad || after_write_bad || value_bad;
    assign error_code  = end_bad         ? pscmd_pkg::STATE_PACKET_ERR :
                         sum_bad         ? pscmd_pkg::STATE_CHECKSUM :
                         (format_bad || cmd_len_bad) ? pscmd_pkg::STATE_PACKET_ERR :
                         life_bad        ? pscmd_pkg::STATE_ACCEPT_ERR :
                         selector_bad    ? pscmd_pkg::STATE_PARAM_ERR :
                         auth_bad        ? pscmd_pkg::STATE_SECURE_ERR :
                         after_write_bad ? pscmd_pkg::STATE_ACCEPT_ERR :
                         pscmd_pkg::STATE_PARAM_ERR;

    // Receiver and command sequencer
    logic rx_take;

    assign rx_take = rx_valid && enable;

    always_comb begin
        next_state = state;
        unique case (state)
            pscmd_pkg::PSCMD_WAIT_START: begin
                if (rx_take && rx_data == pscmd_pkg::CMD_START_MARKER) begin
                    next_state = pscmd_pkg::PSCMD_LEN_HIGH;
                end
            end
            pscmd_pkg::PSCMD_LEN_HIGH:   if (rx_take) next_state = pscmd_pkg::PSCMD_LEN_LOW;
            pscmd_pkg::PSCMD_LEN_LOW:    if (rx_take) next_state = pscmd_pkg::PSCMD_OPCODE;
            pscmd_pkg::PSCMD_OPCODE:     if (rx_take) next_state = pscmd_pkg::PSCMD_SELECTOR;
            pscmd_pkg::PSCMD_SELECTOR:   if (rx_take) next_state = pscmd_pkg::PSCMD_VALUE;
            pscmd_pkg::PSCMD_VALUE:      if (rx_take) next_state = pscmd_pkg::PSCMD_CHECK_BYTE;
            pscmd_pkg::PSCMD_CHECK_BYTE: if (rx_take) next_state = pscmd_pkg::PSCMD_END_BYTE;
            pscmd_pkg::PSCMD_END_BYTE:   if (rx_take) next_state = pscmd_pkg::PSCMD_EVALUATE;
            // Foreign opcode is dropped without a reply unless a check fails or the function is already off
            pscmd_pkg::PSCMD_EVALUATE: begin
                if (error_found || already_off) begin
                    next_state = pscmd_pkg::PSCMD_REPLY;
                end else if (opcode != pscmd_pkg::OPCODE_SET_PARAM) begin
                    next_state = pscmd_pkg::PSCMD_WAIT_START;
                end else begin
                    next_state = pscmd_pkg::PSCMD_FLASH;
                end
            end
            pscmd_pkg::PSCMD_FLASH: begin
                if (flash_done) begin
                    next_state = pscmd_pkg::PSCMD_REPLY;
                end
            end
            pscmd_pkg::PSCMD_REPLY: begin
                if (reply_done) begin
                    next_state = pscmd_pkg::PSCMD_WAIT_START;
                end
            end
            default: next_state = pscmd_pkg::PSCMD_WAIT_START;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= pscmd_pkg::PSCMD_WAIT_START;
        end else begin
            state <= next_state;
        end
    end

    // Received bytes, each held from its own state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            len_high   <= 8'h00;
            len_low    <= 8'h00;
            opcode     <= 8'h00;
            selector   <= 8'h00;
            value      <= 8'h00;
            check_byte <= 8'h00;
            end_byte   <= 8'h00;
        end else if (rx_take) begin
            if (state == pscmd_pkg::PSCMD_LEN_HIGH)   len_high   <= rx_data;
            if (state == pscmd_pkg::PSCMD_LEN_LOW)    len_low    <= rx_data;
            if (state == pscmd_pkg::PSCMD_OPCODE)     opcode     <= rx_data;
            if (state == pscmd_pkg::PSCMD_SELECTOR)   selector   <= rx_data;
            if (state == pscmd_pkg::PSCMD_VALUE)      value      <= rx_data;
            if (state == pscmd_pkg::PSCMD_CHECK_BYTE) check_byte <= rx_data;
            if (state == pscmd_pkg::PSCMD_END_BYTE)   end_byte   <= rx_data;
        end
    end

    // Flash request held until the controller answers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flash_req   <= 1'b0;
            flash_index <= 2'h0;
        end else if (state == pscmd_pkg::PSCMD_EVALUATE &&
                     next_state == pscmd_pkg::PSCMD_FLASH) begin
            flash_req   <= 1'b1;
            flash_index <= sel_index;                   // Upper value bits never stored
        end else if (flash_done) begin
            flash_req <= 1'b0;
        end
    end

    // Disable bits only ever set; stored copy loaded after reset, then ORed in every cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            function_disabled <= 4'h0;
            loaded            <= 1'b0;
        end else if (!loaded) begin
            function_disabled <= stored_disables;
            loaded            <= 1'b1;
        end else begin
            function_disabled <= function_disabled | stored_disables;
            if (state == pscmd_pkg::PSCMD_FLASH && flash_done && !flash_fail) begin
                function_disabled[flash_index] <= 1'b1;
            end
        end
    end

    // Level-two key off also shuts init and return
    assign init_allowed           = !function_disabled[0] && !function_disabled[2];
    assign return_request_allowed = !function_disabled[2];

    // Reply contents
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reply_start     <= 1'b0;
            reply_code      <= 8'h00;
            reply_state     <= 8'h00;
            reply_detail    <= 32'h0000_0000;
            last_state_code <= 8'h00;
        end else begin
            reply_start <= 1'b0;
            if (state == pscmd_pkg::PSCMD_EVALUATE && next_state == pscmd_pkg::PSCMD_REPLY) begin
                reply_start     <= 1'b1;
                reply_detail    <= pscmd_pkg::UNUSED_PATTERN;
                reply_code      <= error_found ? pscmd_pkg::REPLY_CODE_ERR :
                                                 pscmd_pkg::REPLY_CODE_OK;
                reply_state     <= error_found ? error_code : pscmd_pkg::STATE_OK;
                last_state_code <= error_found ? error_code : pscmd_pkg::STATE_OK;
            end else if (state == pscmd_pkg::PSCMD_FLASH && flash_done) begin
                reply_start     <= 1'b1;
                reply_code      <= flash_fail ? pscmd_pkg::REPLY_CODE_ERR :
                                                pscmd_pkg::REPLY_CODE_OK;
                reply_state     <= flash_fail ? pscmd_pkg::STATE_FLASH_ERR :
                                                pscmd_pkg::STATE_OK;
                reply_detail    <= flash_fail ? flash_status :
                                                pscmd_pkg::UNUSED_PATTERN;
                last_state_code <= flash_fail ? pscmd_pkg::STATE_FLASH_ERR :
                                                pscmd_pkg::STATE_OK;
            end
        end
    end

    pscmd_reply_tx u_reply (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .start         (reply_start),
        .reply_code    (reply_code),
        .state_code    (reply_state),
        .detail_word   (reply_detail),
        .fail_location (pscmd_pkg::UNUSED_PATTERN),
        .done          (reply_done),
        .tx_valid      (tx_valid),
        .tx_data       (tx_data),
        .tx_ready      (tx_ready)
    );

endmodule

// ---- design/pscmd_pkg.sv ----
package pscmd_pkg;

    // Packet framing bytes
    localparam logic [7:0]  CMD_START_MARKER  = 8'h01;
    localparam logic [7:0]  DATA_START_MARKER = 8'h81;
    localparam logic [7:0]  PACKET_END_MARKER = 8'h03;
    localparam logic [7:0]  OPCODE_SET_PARAM  = 8'h51;
    localparam logic [15:0] CMD_LENGTH        = 16'h0003;
    localparam logic [7:0]  REPLY_LEN_HIGH    = 8'h00;
    localparam logic [7:0]  REPLY_LEN_LOW     = 8'h0A;
    localparam logic [7:0]  REPLY_CODE_OK     = 8'h51;
    localparam logic [7:0]  REPLY_CODE_ERR    = 8'hD1;
    localparam logic [31:0] UNUSED_PATTERN    = 32'h0FFF_FFFF;
    localparam int          REPLY_BYTES       = 15;

    // State codes carried in replies
    localparam logic [7:0]  STATE_OK          = 8'h00;
    localparam logic [7:0]  STATE_PACKET_ERR  = 8'h01;
    localparam logic [7:0]  STATE_CHECKSUM    = 8'h02;
    localparam logic [7:0]  STATE_ACCEPT_ERR  = 8'h03;
    localparam logic [7:0]  STATE_PARAM_ERR   = 8'h04;
    localparam logic [7:0]  STATE_SECURE_ERR  = 8'h05;
    localparam logic [7:0]  STATE_FLASH_ERR   = 8'h06;

    // Parameter selectors
    localparam logic [7:0]  SEL_INIT          = 8'h01;
    localparam logic [7:0]  SEL_BOOT_LOCK     = 8'h02;
    localparam logic [7:0]  SEL_L2_KEY        = 8'h03;
    localparam logic [7:0]  SEL_L1_KEY        = 8'h04;

    // Authentication levels
    localparam logic [1:0]  AUTH_LEVEL0       = 2'h0;
    localparam logic [1:0]  AUTH_LEVEL1       = 2'h1;
    localparam logic [1:0]  AUTH_LEVEL2       = 2'h2;

    // Register map, byte addresses
    localparam logic [7:0]  REG_CONTROL       = 8'h00;
    localparam logic [7:0]  REG_LIFE_PERMIT   = 8'h04;
    localparam logic [7:0]  REG_STATUS        = 8'h08;
    localparam logic        CONTROL_RESET     = 1'b1;
    localparam logic [15:0] LIFE_PERMIT_RESET = 16'hFFFF;
    localparam int          STATUS_CODE_LSB   = 8;
    localparam int          STATUS_BUSY_BIT   = 16;

    typedef enum logic [3:0] {
        PSCMD_WAIT_START = 4'b0000,
        PSCMD_LEN_HIGH   = 4'b0001,
        PSCMD_LEN_LOW    = 4'b0011,
        PSCMD_OPCODE     = 4'b0010,
        PSCMD_SELECTOR   = 4'b0110,
        PSCMD_VALUE      = 4'b0111,
        PSCMD_CHECK_BYTE = 4'b0101,
        PSCMD_END_BYTE   = 4'b0100,
        PSCMD_EVALUATE   = 4'b1100,
        PSCMD_FLASH      = 4'b1101,
        PSCMD_REPLY      = 4'b1111
    } pscmd_state_e;

endpackage

// ---- design/pscmd_reply_tx.sv ----
`timescale 1ns/10ps
module pscmd_reply_tx (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Reply request
    input  wire logic        start,
    input  wire logic [7:0]  reply_code,
    input  wire logic [7:0]  state_code,
    input  wire logic [31:0] detail_word,
    input  wire logic [31:0] fail_location,
    output logic             done,
    // Byte stream out
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    input  wire logic        tx_ready
);

    logic [3:0]  idx;
    logic [7:0]  sum;
    logic [95:0] body_q;
    logic [7:0]  next_byte;
    logic        take;

    assign take      = tx_valid && tx_ready;
    assign done      = take && (idx == 4'(pscmd_pkg::REPLY_BYTES - 1));
    // Body shifts out most significant byte first
    assign next_byte = (idx < 4'd12)  ? body_q[95:88] :
                       (idx == 4'd12) ? 8'h00 - sum : pscmd_pkg::PACKET_END_MARKER;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_valid <= 1'b0;
            tx_data  <= 8'h00;
            idx      <= 4'h0;
            sum      <= 8'h00;
            body_q   <= 96'h0;
        end else if (start && !tx_valid) begin
            tx_valid <= 1'b1;
            tx_data  <= pscmd_pkg::DATA_START_MARKER;
            idx      <= 4'h0;
            sum      <= 8'h00;
            body_q   <= {pscmd_pkg::REPLY_LEN_HIGH, pscmd_pkg::REPLY_LEN_LOW, reply_code,
                         state_code, detail_word, fail_location};
        end else if (done) begin
            tx_valid <= 1'b0;
        end else if (take) begin
            idx     <= idx + 4'd1;
            tx_data <= next_byte;
            body_q  <= {body_q[87:0], 8'h00};
            if (idx < 4'd12) begin
                sum <= sum + next_byte;
            end
        end
    end

endmodule

// ---- sim/pscmd_asserts.sv ----
`timescale 1ns/10ps
module pscmd_asserts (
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Bus and link
    input  wire logic       hreadyout,
    input  wire logic       hresp,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_ready,
    // Flash and gates
    input  wire logic       flash_req,
    input  wire logic [1:0] flash_index,
    input  wire logic       flash_done,
    input  wire logic       flash_fail,
    input  wire logic [3:0] function_disabled,
    input  wire logic       init_allowed,
    input  wire logic       return_request_allowed
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_bus_okay; hreadyout && !hresp; endproperty
    property p_reply_start; $rose(tx_valid) |-> tx_data == 8'h81; endproperty
    property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
    property p_no_reenable; !(|($past(function_disabled) & ~function_disabled)); endproperty
    property p_l2_gate; function_disabled[2] |-> !init_allowed && !return_request_allowed;
    endproperty
    property p_skip_write; flash_req |-> !function_disabled[flash_index]; endproperty
    property p_req_hold; flash_req && !flash_done |=> flash_req && $stable(flash_index);
    endproperty
    property p_write_ok;
        flash_req && flash_done && !flash_fail |=> function_disabled[$past(flash_index)];
    endproperty
    property p_write_fail;
        flash_req && flash_done && flash_fail |=> function_disabled == $past(function_disabled);
    endproperty
    property p_flash_reply; flash_req && flash_done |-> ##2 tx_valid && tx_data == 8'h81;
    endproperty
    a_bus_okay: assert property (p_bus_okay)
        else $error("bus not okay");
    a_reply_start: assert property (p_reply_start)
        else $error("bad reply start");
    a_tx_hold: assert property (p_tx_hold)
        else $error("byte changed in stall");
    a_no_reenable: assert property (p_no_reenable)
        else $error("function re-enabled");
    a_l2_gate: assert property (p_l2_gate)
        else $error("gate still open");
    a_skip_write: assert property (p_skip_write)
        else $error("write to disabled");
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped");
    a_write_ok: assert property (p_write_ok)
        else $error("write not applied");
    a_write_fail: assert property (p_write_fail)
        else $error("failed write applied");
    a_flash_reply: assert property (p_flash_reply)
        else $error("no reply after flash");
    c_flash_fail: cover property (flash_req && flash_done && flash_fail);
    c_reply: cover property ($rose(tx_valid));
    c_stall: cover property (tx_valid && !tx_ready);
endmodule

// ---- sim/pscmd_host.sv ----
`timescale 1ns/10ps
module pscmd_host (
    // Clock and pacing
    input  wire logic       hclk,
    input  wire logic       slow,
    // Reply stream
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready,
    // Command stream
    output logic            rx_valid,
    output logic [7:0]      rx_data
);
    logic [7:0] q [$];
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b1;
    end
    // Slow host drops ready every other cycle of the reply
    always @(posedge hclk) begin
        if (tx_valid && tx_ready) q.push_back(tx_data);
        tx_ready <= slow ? !tx_ready : 1'b1;
    end
    // Junk byte first, released line shows inverted data
    task send(input logic [55:0] body);
        logic [71:0] f;
        f = {8'hA5, pscmd_pkg::CMD_START_MARKER, body};
        for (int i = 0; i < 9; i++) begin
            @(posedge hclk);
            rx_valid <= 1'b1;
            rx_data  <= f[71-8*i-:8];
            @(posedge hclk);
            rx_valid <= 1'b0;
            rx_data  <= ~f[71-8*i-:8];
        end
    endtask
endmodule

// ---- sim/test_pscmd_handler.sv ----
`timescale 1ns/10ps
module test_pscmd_handler;
    typedef struct packed {
        logic [7:0] sel;
        logic [7:0] val;
        logic [2:0] bad;
        logic [1:0] al;
        logic       ew, ff, fl;
        logic [7:0] st;
    } pscmd_row_s;
    localparam logic [31:0] FSTAT = 32'h0000_5A3C;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
    logic        ewp = 1'b0, flash_done = 1'b0, flash_fail = 1'b0, hreadyout, hresp;
    logic        tx_valid, tx_ready, rx_valid, flash_req, init_allowed, ret_allowed;
    logic [1:0]  htrans = 2'h0, auth = 2'h0, fcnt = 2'h0, flash_index;
    logic [3:0]  stored = 4'h0, function_disabled;
    logic [7:0]  tx_data, rx_data;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
    int          failures = 0, compares = 0, nflash = 0, cycles = 0;
    pscmd_row_s  rows [15] = '{
        '{8'h01, 8'hF8, 3'h0, 2'h0, 1'b0, 1'b0, 1'b1, 8'h00},
        '{8'h01, 8'h00, 3'h0, 2'h0, 1'b0, 1'b0, 1'b0, 8'h00},
        '{8'h02, 8'h00, 3'h1, 2'h1, 1'b0, 1'b0, 1'b0, 8'h01},
        '{8'h02, 8'h00, 3'h2, 2'h1, 1'b0, 1'b0, 1'b0, 8'h02},
        '{8'h02, 8'h00, 3'h4, 2'h1, 1'b0, 1'b0, 1'b0, 8'h01},
        '{8'h02, 8'h00, 3'h3, 2'h1, 1'b0, 1'b0, 1'b0, 8'h01},
        '{8'h05, 8'h00, 3'h0, 2'h1, 1'b0, 1'b0, 1'b0, 8'h04},
        '{8'h03, 8'h00, 3'h0, 2'h1, 1'b0, 1'b0, 1'b0, 8'h05},
        '{8'h04, 8'h00, 3'h0, 2'h1, 1'b1, 1'b0, 1'b0, 8'h03},
        '{8'h02, 8'h01, 3'h0, 2'h1, 1'b0, 1'b0, 1'b0, 8'h04},
        '{8'h03, 8'h01, 3'h0, 2'h0, 1'b0, 1'b0, 1'b0, 8'h05},
        '{8'h02, 8'h00, 3'h0, 2'h1, 1'b0, 1'b1, 1'b1, 8'h06},
        '{8'h02, 8'h00, 3'h0, 2'h1, 1'b0, 1'b0, 1'b1, 8'h00},
        '{8'h04, 8'h00, 3'h0, 2'h2, 1'b0, 1'b0, 1'b1, 8'h00},
        '{8'h03, 8'h00, 3'h0, 2'h2, 1'b0, 1'b0, 1'b1, 8'h00}};

    pscmd_handler i_pscmd_handler (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .lifecycle_state(4'h3), .authentication_level(auth), .encrypted_write_pending(ewp),
        .stored_disables(stored), .flash_req(flash_req), .flash_index(flash_index),
        .flash_done(flash_done), .flash_fail(flash_fail), .flash_status(FSTAT),
        .function_disabled(function_disabled), .init_allowed(init_allowed),
        .return_request_allowed(ret_allowed));
    pscmd_host i_pscmd_host (.hclk(hclk), .slow(slow), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data));

    always #10 hclk = ~hclk;
    // Flash answers three cycles after a request
    always @(posedge hclk) begin
        fcnt       <= (flash_req && !flash_done) ? fcnt + 2'h1 : 2'h0;
        flash_done <= flash_req && !flash_done && fcnt == 2'h2;
        if (flash_done) nflash <= nflash + 1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            final_report();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h00_0000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task run(input pscmd_row_s r);
        logic [119:0] x;
        logic [7:0]   s, length_low_byte, sum;
        int           n0;
        length_low_byte = r.bad[2] ? 8'h02 : 8'h03;
        sum = 8'h00 - length_low_byte - 8'h51 - r.sel - r.val;
        n0 = nflash;
        {auth, ewp, flash_fail} <= {r.al, r.ew, r.ff};
        i_pscmd_host.q.delete();
        i_pscmd_host.send({8'h00, length_low_byte, 8'h51, r.sel, r.val, sum + {7'h00, r.bad[1]},
            r.bad[0] ? 8'h55 : 8'h03});
        while (i_pscmd_host.q.size() < 15) @(posedge hclk);
        x = {24'h81_000A, r.st == 8'h00 ? 8'h51 : 8'hD1, r.st,
            r.st == 8'h06 ? FSTAT : 32'h0FFF_FFFF, 32'h0FFF_FFFF, 16'h0003};
        s = 8'h00;
        for (int i = 1; i < 13; i++) s = s - x[119-8*i-:8];
        x[15:8] = s;
        for (int i = 0; i < 15; i++) check(i_pscmd_host.q[i], x[119-8*i-:8]);
        check(nflash - n0, {31'h0, r.fl});
        $display("frame sel %h done", r.sel);
    endtask
    task final_report;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h0000_0001);
        ahb(1'b0, 8'h04, 32'h0);
        check(rd, 32'h0000_FFFF);
        ahb(1'b0, 8'h0C, 32'h0);
        check(rd, 32'h0000_0000);
        ahb(1'b1, 8'h04, 32'h0000_FFF7);
        run('{8'h02, 8'h00, 3'h0, 2'h1, 1'b0, 1'b0, 1'b0, 8'h03});
        ahb(1'b1, 8'h04, 32'h0000_FFFF);
        for (int i = 0; i < 15; i++) begin
            slow <= i[0];
            run(rows[i]);
        end
        check({30'h0, init_allowed, ret_allowed}, 32'h0);
        ahb(1'b0, 8'h08, 32'h0);
        check({28'h0, rd[3:0]}, 32'h0000_000F);
        $display("register test done");
        ahb(1'b1, 8'h00, 32'h0);
        i_pscmd_host.send({8'h00, 8'h03, 8'h51, 8'h01, 8'h00, 8'hAB, 8'h03});
        ahb(1'b0, 8'h08, 32'h0);
        check({31'h0, rd[16]}, 32'h0);
        $display("enable test done");
        {hresetn, stored} <= {1'b0, 4'h4};
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        check({27'h0, function_disabled, init_allowed}, 32'h0000_0008);
        $display("second reset done");
        final_report();
    end
endmodule
bind pscmd_handler pscmd_asserts i_pscmd_asserts (.hclk(hclk), .hresetn(hresetn),
    .hreadyout(hreadyout), .hresp(hresp), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .flash_req(flash_req), .flash_index(flash_index),
    .flash_done(flash_done), .flash_fail(flash_fail), .function_disabled(function_disabled),
    .init_allowed(init_allowed), .return_request_allowed(return_request_allowed));
